// ==== hw/sar_adc_control.sv ====
/*
  Control logic of a four-channel 8-bit successive-approximation converter
  with an AXI4-Lite register slave, the trial code for the internal DAC,
  the channel multiplexer select and the port C digital read path.
  Register accesses start conversions and clear the done flag; stop, halt
  and power-off drop the sequence in progress; result and flag are
  written on aclk whichever conversion clock runs.
  Assumes the comparator output, the RC oscillator level and the mode
  inputs are synchronous to aclk, the comparator settles within one aclk
  cycle of a new trial code, the RC oscillator runs below half the aclk
  rate so that each of its rising edges is seen, and the bus master keeps
  at most one write and one read outstanding.
*/
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps

module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int ADDR_WIDTH = 4
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    comparator_above,
  input  wire logic                    rc_oscillator,
  input  wire logic                    stop_mode,
  input  wire logic                    halt_mode,
  input  wire logic [PORT_C_WIDTH-1:0] port_c_pins,
  output logic [RESULT_WIDTH-1:0]      dac_code,
  output logic [1:0]                   analog_channel,
  output logic                         converter_enabled,
  output logic [PORT_C_WIDTH-1:0]      port_c_read
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // Word index of a byte address
  function automatic logic [ADDR_WIDTH-3:0] word_of(
    input logic [ADDR_WIDTH-1:0] addr
  );
    word_of = addr[ADDR_WIDTH-1:2];
  endfunction

  // One approximation step: keep or drop bit idx, try the next lower one
  // Bit 0 has no lower neighbour, so the last step only decides
  function automatic logic [7:0] sar_step(
    input logic [7:0] trial,
    input logic [2:0] idx,
    input logic       keep
  );
    logic [7:0] code;
    code = trial;
    code[idx] = keep;
    if (idx != 3'h0) begin
      code[idx - 3'h1] = 1'b1;
    end
    sar_step = code;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Register contents, held write request, sequencer
  logic                  rc_select;
  logic                  power_on;
  logic [1:0]            channel;
  logic                  done_flag;
  logic [7:0]            result;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  rc_prev;
  logic [4:0]            step_count;
  conv_state_t           state;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Handshakes; a write fires once both halves are held, unanswered
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take  = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic rd_take = s_axi_arvalid && s_axi_arready;

  // Register decode of the held write and the offered read address
  wire logic wr_ctrl = word_of(aw_addr) == word_of(ADDR_CONTROL_STATUS);
  wire logic wr_res  = word_of(aw_addr) == word_of(ADDR_RESULT);
  wire logic rd_ctrl = word_of(s_axi_araddr) == word_of(ADDR_CONTROL_STATUS);
  wire logic rd_res  = word_of(s_axi_araddr) == word_of(ADDR_RESULT);

  // Any access to either register, read or write
  wire logic access = (wr_fire && (wr_ctrl || wr_res))
                   || (rd_take && (rd_ctrl || rd_res));

  // Status byte; bits 4-2 always zero
  wire logic [7:0] status_byte = {done_flag, rc_select, power_on,
                                  3'h0, channel};

  // Response codes: mapped registers okay, anything else slave error
  wire logic [1:0] write_resp = (wr_ctrl || wr_res) ? RESP_OKAY : RESP_SLVERR;
  wire logic [1:0] read_resp  = (rd_ctrl || rd_res) ? RESP_OKAY : RESP_SLVERR;

  // Read byte by address; unmapped reads give zero
  wire logic [7:0]  read_byte = rd_ctrl ? status_byte
                              : rd_res  ? result
                              : 8'h00;
  wire logic [31:0] read_word = {24'h000000, read_byte};

  // Control write that lands at this edge
  wire logic ctrl_write = wr_fire && wr_ctrl && w_strb[0];

  // ----------------------------------------------------------------------
  // Conversion timing decode
  // ----------------------------------------------------------------------

  // Conversion clock: RC oscillator edge or every bus clock
  wire logic rc_rise   = rc_oscillator && !rc_prev;
  wire logic conv_tick = rc_select ? rc_rise : 1'b1;

  // Power-on as it stands after this edge, so a powering-up write starts
  wire logic next_power_on = ctrl_write ? w_data[POWER_ON_BIT] : power_on;

  // Stop, halt or power-off kill any conversion; wait mode does not
  wire logic abort     = stop_mode || halt_mode
                      || !next_power_on;
  // Every fourth tick decides a bit; the 32nd tick completes
  wire logic converting = state == CONV_RUN;
  wire logic decide    = converting && conv_tick
                      && step_count[1:0] == DECIDE_PHASE;
  // Step 4k+3 decides bit 7-k
  wire logic [2:0] bit_idx = 3'h7 - step_count[4:2];
  wire logic finish    = decide && step_count == CONV_LAST_STEP;
  wire logic [7:0] next_trial = sar_step(dac_code, bit_idx,
                                         comparator_above);

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------

  // Address held from its take until the response is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data held the same way; either channel may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Response two cycles after the later half is taken, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_resp;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits; result register ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_select <= RC_SELECT_RESET;
      power_on  <= POWER_ON_RESET;
      channel   <= CHANNEL_RESET;
    end else if (ctrl_write) begin
      rc_select <= w_data[RC_SELECT_BIT];
      power_on  <= w_data[POWER_ON_BIT];
      channel   <= w_data[CHANNEL_MSB:CHANNEL_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------

  // Data shows the register before this access clears the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= read_resp;
      s_axi_rdata   <= read_word;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------

  // RC oscillator edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_prev <= 1'b0;
    end else begin
      rc_prev <= rc_oscillator;
    end
  end

  // Start on access, step on each tick; abort beats a start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= CONV_IDLE;
      step_count <= 5'h00;
    end else if (abort) begin
      state      <= CONV_IDLE;
      step_count <= 5'h00;
    end else if (access) begin
      state      <= CONV_RUN;
      step_count <= 5'h00;
    end else if (converting && conv_tick) begin
      step_count <= step_count + 5'h01;
      if (finish) begin
        state <= CONV_IDLE;
      end
    end
  end

  // Trial code: MSB first on a start, one bit per decide tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code <= 8'h00;
    end else if (access && !abort) begin
      dac_code <= SAR_FIRST_TRIAL;
    end else if (decide && !abort) begin
      dac_code <= next_trial;
    end
  end

  // Result written only by a completed conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= RESULT_RESET;
    end else if (finish && !abort) begin
      result <= next_trial;
    end
  end

  // Flag set on completion, cleared by access; completion wins a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
    end else if (finish && !abort) begin
      done_flag <= 1'b1;
    end else if (access) begin
      done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------------

  // Selected analog pin reads zero, the rest pass through
  // Mask only while powered, so a powered-off converter leaves pins digital
  wire logic [2:0] analog_pin = 3'(FIRST_ANALOG_PIN) - {1'b0, channel};
  wire logic [PORT_C_WIDTH-1:0] analog_mask =
    power_on ? (PORT_C_WIDTH'(1) << analog_pin) : '0;

  // Registered pin read, channel and enable copies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_read       <= '0;
      analog_channel    <= CHANNEL_RESET;
      converter_enabled <= 1'b0;
    end else begin
      port_c_read       <= port_c_pins & ~analog_mask;
      analog_channel    <= channel;
      converter_enabled <= power_on;
    end
  end

endmodule

// ==== hw/sar_adc_pkg.sv ====
/*
  Constants shared by the successive-approximation converter control block:
  register byte offsets, control/status field positions, reset values,
  conversion timing counts and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package sar_adc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_RESULT         = 4'h4;

  // ----------------------------------------------------------------------
  // Control/status fields
  // ----------------------------------------------------------------------
  localparam int DONE_FLAG_BIT   = 7;
  localparam int RC_SELECT_BIT   = 6;
  localparam int POWER_ON_BIT    = 5;
  localparam int CHANNEL_LSB     = 0;
  localparam int CHANNEL_MSB     = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic       RC_SELECT_RESET = 1'b0;
  localparam logic       POWER_ON_RESET  = 1'b0;
  localparam logic [1:0] CHANNEL_RESET   = 2'h0;
  localparam logic [7:0] RESULT_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // Conversion timing, widths and analog pin position
  // ----------------------------------------------------------------------
  localparam int         RESULT_WIDTH     = 8;
  localparam int         CONV_CYCLES      = 32;
  localparam logic [4:0] CONV_LAST_STEP   = 5'(CONV_CYCLES - 1);
  localparam logic [1:0] DECIDE_PHASE     = 2'h3;
  localparam logic [7:0] SAR_FIRST_TRIAL  = 8'h80;
  localparam int         PORT_C_WIDTH     = 8;
  localparam int         FIRST_ANALOG_PIN = 6;

  // ----------------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

endpackage

// ==== testbench/analog_sources.sv ====
/*
  Four analog sources feeding the converter's comparator.
  Assumes the bench sets the four 8-bit levels, one byte per channel.
*/
`timescale 1ns/1ps
module analog_sources (
  input  wire logic [7:0]  dac_code,
  input  wire logic [1:0]  analog_channel,
  input  wire logic [31:0] levels,
  output logic             comparator_above
);
  // Selected source against the trial code
  assign comparator_above = levels[analog_channel*8 +: 8] >= dac_code;
endmodule

// ==== testbench/sar_adc_control_monitor.sv ====
/*
  Port checker for the converter control block.
  Assumes one clock domain and synchronous active-low reset.
*/
`timescale 1ns/1ps
module sar_adc_control_monitor
  import sar_adc_pkg::*;
#(
  parameter int ADDR_WIDTH = 4
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [7:0]            port_c_pins,
  input wire logic [7:0]            port_c_read,
  input wire logic [7:0]            dac_code,
  input wire logic [1:0]            analog_channel,
  input wire logic                  converter_enabled
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_WIDTH-1:0] rd_addr;
  logic [7:0]            pins_q;
  // Address of the read in flight, pins one cycle back
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    pins_q <= port_c_pins;
  end
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_b_refused: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while answering");
  a_r_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_unused_zero: assert property (
    s_axi_rvalid && rd_addr == ADDR_CONTROL_STATUS |->
    s_axi_rdata[4:2] == 3'h0) else $error("unused status bits set");
  a_sel_pin_zero: assert property (
    converter_enabled |-> !port_c_read[3'd6 - {1'b0, analog_channel}])
    else $error("selected analog pin reads one");
  a_other_pins: assert property ($past(aresetn) |->
    port_c_read[2:0] == pins_q[2:0] && port_c_read[7] == pins_q[7])
    else $error("digital pin read wrong");
  a_dac_step: assert property ($changed(dac_code) |->
    dac_code == SAR_FIRST_TRIAL || dac_code == 8'h00 ||
    $countones(dac_code ^ $past(dac_code)) <= 2)
    else $error("trial code jumped");
  c_write: cover property (s_axi_bvalid);
  c_chan3: cover property (converter_enabled && analog_channel == 2'h3);
  c_full: cover property (dac_code == 8'hFF);
endmodule

bind sar_adc_control sar_adc_control_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .port_c_pins,
  .port_c_read, .dac_code, .analog_channel, .converter_enabled);

// ==== testbench/sar_adc_control_test.sv ====
/*
  Self-checking bench: register master, analog sources, result model.
  Assumes 32-cycle conversions on the bus clock.
*/
`timescale 1ns/1ps
module sar_adc_control_test;
  import sar_adc_pkg::*;
  localparam int FL = 1 << DONE_FLAG_BIT;
  localparam int RC = 1 << RC_SELECT_BIT;
  localparam int ON = 1 << POWER_ON_BIT;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, comparator_above;
  logic        rc_oscillator, stop_mode, halt_mode, converter_enabled;
  logic        rc_run;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot, rc_cnt;
  logic [1:0]  s_axi_bresp, s_axi_rresp, analog_channel, rsp;
  logic [31:0] s_axi_wdata, s_axi_rdata, lv, rd;
  logic [7:0]  dac_code, port_c_pins, port_c_read, pins_q;
  int          n_mismatch, checked, seed, cyc;

  sar_adc_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .comparator_above, .rc_oscillator, .stop_mode,
    .halt_mode, .port_c_pins, .dac_code, .analog_channel,
    .converter_enabled, .port_c_read);
  analog_sources src (.dac_code, .analog_channel, .levels(lv),
    .comparator_above);

  // Clock, slow RC source, random pins, hang limit
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  assign rc_oscillator = rc_cnt[2];
  always @(posedge aclk) begin
    rc_cnt <= rc_run ? rc_cnt + 3'h1 : 3'h0;
    port_c_pins <= 8'($random(seed));
    pins_q <= port_c_pins;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Successive approximation reference
  function automatic int sar(input int lvl);
    int code;
    code = 0;
    for (int b = 7; b >= 0; b--)
      if (lvl >= (code | (1 << b))) code = code | (1 << b);
    return code;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input int d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    fork
      begin @(posedge aclk iff s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin @(posedge aclk iff s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    @(posedge aclk iff s_axi_bvalid);
    chk("write resp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input int e, input string nm);
    rd_reg(a);
    chk(nm, 32'(e), rd);
    chk("read resp", 32'(RESP_OKAY), 32'(rsp));
  endtask

  task automatic close_out;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, stop_mode, halt_mode, rc_run} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 14'h0000;
    {s_axi_wdata, lv, port_c_pins} = 72'h0;
    s_axi_wstrb = 4'hF;
    seed = 13;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_CONTROL_STATUS, 0, "status reset");
    rchk(ADDR_RESULT, 0, "result reset");
    rd_reg(4'h8);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
    chk("unmapped data", 32'h0, rd);
    // Every channel, full scale and ground among the levels
    for (int ch = 0; ch < 4; ch++) begin
      lv <= {$random(seed)} & 32'hFFFF0000 | 32'h000000FF;
      wr(ADDR_CONTROL_STATUS, ON | ch);
      repeat (40) @(posedge aclk);
      rchk(ADDR_CONTROL_STATUS, FL | ON | ch, "done");
      chk("first trial", 32'h80, 32'(dac_code));
      chk("pins", 32'(pins_q & ~(8'h40 >> ch)),
          32'(port_c_read));
      chk("channel", 32'(ch), 32'(analog_channel));
      chk("enabled", 32'h1, 32'(converter_enabled));
      rchk(ADDR_RESULT, sar(lv[ch*8 +: 8]), "result");
      rchk(ADDR_CONTROL_STATUS, ON | ch, "cleared");
    end
    // Completion exactly 32 cycles after a read start, then overwrite
    rd_reg(ADDR_CONTROL_STATUS);
    repeat (29) @(posedge aclk);
    rchk(ADDR_CONTROL_STATUS, ON | 3, "flag early");
    lv <= ~lv;
    repeat (30) @(posedge aclk);
    rchk(ADDR_CONTROL_STATUS, FL | ON | 3, "flag on time");
    rchk(ADDR_RESULT, sar(lv[31:24]), "overwrite");
    // RC clock: nothing while it stands, a result once it runs
    wr(ADDR_CONTROL_STATUS, RC | ON | 2);
    repeat (40) @(posedge aclk);
    rchk(ADDR_CONTROL_STATUS, RC | ON | 2, "rc still");
    rc_run <= 1'b1;
    repeat (300) @(posedge aclk);
    rchk(ADDR_CONTROL_STATUS, FL | RC | ON | 2, "rc done");
    rc_run <= 1'b0;
    rchk(ADDR_RESULT, sar(lv[23:16]), "rc result");
    // Power off, stop and halt each drop the conversion
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CONTROL_STATUS, m == 0 ? 1 : ON | 1);
      repeat (10) @(posedge aclk);
      stop_mode <= (m == 1);
      halt_mode <= (m == 2);
      @(posedge aclk);
      stop_mode <= 1'b0;
      halt_mode <= 1'b0;
      repeat (40) @(posedge aclk);
      rchk(ADDR_CONTROL_STATUS, m == 0 ? 1 : ON | 1, "dropped");
      chk("enabled", 32'(m != 0), 32'(converter_enabled));
    end
    // Mid-run reset returns both registers to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ADDR_CONTROL_STATUS, 0, "status re-reset");
    rchk(ADDR_RESULT, 0, "result re-reset");
    close_out();
  end
endmodule
